// >>> addr_table_pkg.sv
// Package with register offsets, field positions and timing counts of the address table access.
package addr_table_pkg;
  localparam logic [15:0] CMD_OFFSET       = 16'h1800;
  localparam logic [15:0] WR_WORD0_OFFSET  = 16'h1801;
  localparam logic [15:0] WR_WORD1_OFFSET  = 16'h1802;
  localparam logic [15:0] RD_WORD0_OFFSET  = 16'h1805;
  localparam logic [15:0] RD_WORD1_OFFSET  = 16'h1806;
  localparam logic [15:0] CMD_STS_OFFSET   = 16'h1808;
  localparam int          CMD_MAKE_BIT     = 2;
  localparam int          CMD_FIRST_BIT    = 1;
  localparam int          CMD_NEXT_BIT     = 0;
  localparam int          VALID_BIT        = 26;
  localparam int          AGE_BIT          = 25;
  localparam int          END_BIT          = 25;
  localparam int          STATIC_BIT       = 24;
  localparam int          FILTER_BIT       = 23;
  localparam int          PRIO_EN_BIT      = 22;
  localparam int          PRIO_HI          = 21;
  localparam int          PRIO_LO          = 19;
  localparam int          PORT_HI          = 18;
  localparam int          PORT_LO          = 16;
  localparam int          WORD1_USED_HI    = 26;
  localparam logic [31:0] WORD0_RESET      = 32'h0000_0000;
  localparam logic [31:0] WORD1_RESET      = 32'h0000_0000;
  localparam int          TABLE_DEPTH      = 8;
  localparam int          INDEX_W          = 3;
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          AGE_TIME_MIN_S   = 300;
  localparam int          AGE_TICK_NS      = 1000000;
  localparam int          AGE_TICK_CYCLES  = AGE_TICK_NS / CLK_PERIOD_NS;
  localparam int          AGE_TICKS        = AGE_TIME_MIN_S * 1000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MAKE = 2'b01,
    ST_SCAN = 2'b11
  } op_state_t;
endpackage : addr_table_pkg

// >>> address_table_manual_access.sv
// Command and write-data registers of the address lookup table with a small entry store.
`timescale 1ns/10ps
// Notes on behaviour
// - Make entry stores both words in table
// - Matching MAC updates or deletes entry
// - Writing zero to command bits does nothing
// - Get first rewinds pointer, loads first valid
// - Get next loads following valid entry
// - Make pending high while make executes
// - Word0 holds first 32 MAC bits
// - Valid bit set validates, clear invalidates
// - Static override forwards unless port disabled
// - Static entries never aged nor learned over
// - Dynamic entries age out after idle time
// - Filter bit drops matching destination
// - Priority enable gates priority field
// - Priority used with enable and global setting
// - Port field encodes destination port set
// - Word1 low half holds last 16 bits
// - Read valid clears on get, sets on find
// - End flag marks walk finished
module address_table_manual_access #(
  parameter int AGE_TICK_CYCLES_P = addr_table_pkg::AGE_TICK_CYCLES,
  parameter int AGE_TICKS_P       = addr_table_pkg::AGE_TICKS
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  // Register port
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  // Forwarding lookup
  input  wire logic [47:0] lookup_da_in,
  input  wire logic [47:0] lookup_sa_in,
  input  wire logic        lookup_sa_valid_in,
  input  wire logic        dest_priority_first_in,
  input  wire logic [2:0]  port_disabled_in,
  output logic             lookup_hit_out,
  output logic [2:0]       lookup_ports_out,
  output logic             lookup_drop_out,
  output logic             lookup_override_out,
  output logic             lookup_prio_valid_out,
  output logic [2:0]       lookup_prio_out,
  // Status
  output logic             make_pending_out
);
  localparam int D = addr_table_pkg::TABLE_DEPTH;
  localparam int W = addr_table_pkg::INDEX_W;

  logic [2:0]  cmd_reg, cmd_next;
  logic [31:0] wr0_reg, wr0_next, wr1_reg, wr1_next;
  logic [31:0] rd0_reg, rd0_next, rd1_reg, rd1_next;
  logic [31:0] ent0_reg [D];
  logic [31:0] ent0_next [D];
  logic [26:0] ent1_reg [D];
  logic [26:0] ent1_next [D];
  logic [31:0] age_reg [D];
  logic [31:0] age_next [D];
  logic [W-1:0] ptr_reg, ptr_next;
  logic [W:0]   scan_reg, scan_next;
  logic         rd_valid_reg, rd_valid_next, rd_end_reg, rd_end_next;
  logic [31:0]  tick_reg, tick_next;
  logic [31:0]  rdata_reg, rdata_next;
  logic         hit_reg, drop_reg, ovr_reg, pv_reg;
  logic [2:0]   ports_reg, prio_reg;
  logic         hit_next, drop_next, ovr_next, pv_next;
  logic [2:0]   ports_next, prio_next;
  addr_table_pkg::op_state_t st_reg, st_next;

  // Decodes the three-bit destination field into a port mask.
  function automatic logic [2:0] port_mask(input logic [2:0] code);
    case (code)
      3'h0: port_mask = 3'h1;
      3'h1: port_mask = 3'h2;
      3'h2: port_mask = 3'h4;
      3'h4: port_mask = 3'h3;
      3'h5: port_mask = 3'h5;
      3'h6: port_mask = 3'h6;
      3'h7: port_mask = 3'h7;
      default: port_mask = 3'h0;
    endcase
  endfunction : port_mask

  // Compares a stored valid entry against a 48-bit address.
  function automatic logic entry_match(input logic [31:0] e0, input logic [26:0] e1,
                                       input logic [47:0] mac);
    entry_match = e1[addr_table_pkg::VALID_BIT] && (e0 == mac[31:0]) && (e1[15:0] == mac[47:32]);
  endfunction : entry_match

  logic        wr_cmd, wr_w0, wr_w1;
  logic        rise_make, rise_first, rise_next;
  logic [W-1:0] match_idx, free_idx, make_idx;
  logic        match_hit, free_hit;
  logic [2:0]  w_cmd;

  always_comb
  begin
    wr_cmd = reg_wr_in && (reg_addr_in == addr_table_pkg::CMD_OFFSET);
    wr_w0  = reg_wr_in && (reg_addr_in == addr_table_pkg::WR_WORD0_OFFSET);
    wr_w1  = reg_wr_in && (reg_addr_in == addr_table_pkg::WR_WORD1_OFFSET);
    w_cmd  = reg_wdata_in[2:0];
    rise_make  = wr_cmd && w_cmd[addr_table_pkg::CMD_MAKE_BIT]
                 && !cmd_reg[addr_table_pkg::CMD_MAKE_BIT];
    rise_first = wr_cmd && w_cmd[addr_table_pkg::CMD_FIRST_BIT]
                 && !cmd_reg[addr_table_pkg::CMD_FIRST_BIT];
    rise_next  = wr_cmd && w_cmd[addr_table_pkg::CMD_NEXT_BIT]
                 && !cmd_reg[addr_table_pkg::CMD_NEXT_BIT];
    match_hit = 1'b0;
    match_idx = '0;
    free_hit  = 1'b0;
    free_idx  = '0;
    for (int i = D - 1; i >= 0; i--)
    begin
      if (entry_match(ent0_reg[i], ent1_reg[i], {wr1_reg[15:0], wr0_reg}))
      begin
        match_hit = 1'b1;
        match_idx = W'(i);
      end
      if (!ent1_reg[i][addr_table_pkg::VALID_BIT])
      begin
        free_hit = 1'b1;
        free_idx = W'(i);
      end
    end
    make_idx = match_hit ? match_idx : free_idx;
  end

  always_comb
  begin
    cmd_next = cmd_reg;
    wr0_next = wr0_reg;
    wr1_next = wr1_reg;
    rd0_next = rd0_reg;
    rd1_next = rd1_reg;
    ptr_next = ptr_reg;
    scan_next = scan_reg;
    rd_valid_next = rd_valid_reg;
    rd_end_next = rd_end_reg;
    st_next = st_reg;
    ent0_next = ent0_reg;
    ent1_next = ent1_reg;
    age_next = age_reg;
    tick_next = (tick_reg >= 32'(AGE_TICK_CYCLES_P - 1)) ? 32'h0 : tick_reg + 32'h1;
    if (wr_cmd)
      cmd_next = w_cmd;
    if (wr_w0)
      wr0_next = reg_wdata_in;
    if (wr_w1)
      wr1_next = {5'h0, reg_wdata_in[addr_table_pkg::WORD1_USED_HI:0]};
    for (int i = 0; i < D; i++)
    begin
      if (!ent1_reg[i][addr_table_pkg::STATIC_BIT] && ent1_reg[i][addr_table_pkg::VALID_BIT])
      begin
        if (lookup_sa_valid_in && entry_match(ent0_reg[i], ent1_reg[i], lookup_sa_in))
          age_next[i] = 32'h0;
        else if (tick_reg == 32'h0)
          age_next[i] = age_reg[i] + 32'h1;
        if (age_reg[i] >= 32'(AGE_TICKS_P))
          ent1_next[i][addr_table_pkg::VALID_BIT] = 1'b0;
      end
    end
    case (st_reg)
      addr_table_pkg::ST_IDLE:
      begin
        if (rise_make)
          st_next = addr_table_pkg::ST_MAKE;
        else if (rise_first || rise_next)
        begin
          rd_valid_next = 1'b0;
          rd_end_next = 1'b0;
          scan_next = rise_first ? '0 : {1'b0, ptr_reg} + (W+1)'(rd_valid_reg);
          st_next = addr_table_pkg::ST_SCAN;
        end
      end
      addr_table_pkg::ST_MAKE:
      begin
        if (match_hit || free_hit)
        begin
          ent0_next[make_idx] = wr0_reg;
          ent1_next[make_idx] = wr1_reg[addr_table_pkg::WORD1_USED_HI:0];
          age_next[make_idx] = 32'h0;
        end
        st_next = addr_table_pkg::ST_IDLE;
      end
      default:
      begin
        if (scan_reg[W])
        begin
          rd_end_next = 1'b1;
          st_next = addr_table_pkg::ST_IDLE;
        end
        else if (ent1_reg[scan_reg[W-1:0]][addr_table_pkg::VALID_BIT])
        begin
          rd_valid_next = 1'b1;
          rd_end_next = (scan_reg[W-1:0] == W'(D - 1));
          ptr_next = scan_reg[W-1:0];
          rd0_next = ent0_reg[scan_reg[W-1:0]];
          rd1_next = {5'h0, ent1_reg[scan_reg[W-1:0]]};
          st_next = addr_table_pkg::ST_IDLE;
        end
        else
          scan_next = scan_reg + (W+1)'(1);
      end
    endcase
    rd1_next[addr_table_pkg::VALID_BIT] = rd_valid_next;
    rd1_next[addr_table_pkg::END_BIT] = rd_end_next;
    rdata_next = 32'h0;
    if (reg_addr_in == addr_table_pkg::CMD_OFFSET)
      rdata_next = {29'h0, cmd_reg};
    else if (reg_addr_in == addr_table_pkg::WR_WORD0_OFFSET)
      rdata_next = wr0_reg;
    else if (reg_addr_in == addr_table_pkg::WR_WORD1_OFFSET)
      rdata_next = wr1_reg;
    else if (reg_addr_in == addr_table_pkg::RD_WORD0_OFFSET)
      rdata_next = rd0_reg;
    else if (reg_addr_in == addr_table_pkg::RD_WORD1_OFFSET)
      rdata_next = rd1_reg;
    else if (reg_addr_in == addr_table_pkg::CMD_STS_OFFSET)
      rdata_next = {30'h0, st_reg == addr_table_pkg::ST_SCAN, st_reg == addr_table_pkg::ST_MAKE};
    if (!reg_rd_in)
      rdata_next = rdata_reg;
  end

  always_comb
  begin
    hit_next = 1'b0;
    ports_next = 3'h0;
    drop_next = 1'b0;
    ovr_next = 1'b0;
    pv_next = 1'b0;
    prio_next = 3'h0;
    for (int i = D - 1; i >= 0; i--)
    begin
      if (entry_match(ent0_reg[i], ent1_reg[i], lookup_da_in))
      begin
        hit_next = 1'b1;
        ports_next = port_mask(ent1_reg[i][addr_table_pkg::PORT_HI:
                                           addr_table_pkg::PORT_LO]);
        drop_next = ent1_reg[i][addr_table_pkg::FILTER_BIT];
        ovr_next = ent1_reg[i][addr_table_pkg::STATIC_BIT] && ent1_reg[i][addr_table_pkg::AGE_BIT];
        pv_next = ent1_reg[i][addr_table_pkg::PRIO_EN_BIT] && dest_priority_first_in;
        prio_next = pv_next ? ent1_reg[i][addr_table_pkg::PRIO_HI:addr_table_pkg::PRIO_LO]
                            : 3'h0;
      end
    end
    if (ovr_next)
      ports_next = ports_next & ~port_disabled_in;
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cmd_reg <= 3'h0;
      wr0_reg <= addr_table_pkg::WORD0_RESET;
      wr1_reg <= addr_table_pkg::WORD1_RESET;
      rd0_reg <= 32'h0;
      rd1_reg <= 32'h0;
      ptr_reg <= '0;
      scan_reg <= '0;
      rd_valid_reg <= 1'b0;
      rd_end_reg <= 1'b0;
      st_reg <= addr_table_pkg::ST_IDLE;
      tick_reg <= 32'h0;
      rdata_reg <= 32'h0;
      for (int i = 0; i < D; i++)
      begin
        ent0_reg[i] <= 32'h0;
        ent1_reg[i] <= 27'h0;
        age_reg[i] <= 32'h0;
      end
      {hit_reg, drop_reg, ovr_reg, pv_reg, ports_reg, prio_reg} <= 10'h0;
    end
    else
    begin
      cmd_reg <= cmd_next;
      wr0_reg <= wr0_next;
      wr1_reg <= wr1_next;
      rd0_reg <= rd0_next;
      rd1_reg <= rd1_next;
      ptr_reg <= ptr_next;
      scan_reg <= scan_next;
      rd_valid_reg <= rd_valid_next;
      rd_end_reg <= rd_end_next;
      st_reg <= st_next;
      tick_reg <= tick_next;
      rdata_reg <= rdata_next;
      ent0_reg <= ent0_next;
      ent1_reg <= ent1_next;
      age_reg <= age_next;
      {hit_reg, drop_reg, ovr_reg, pv_reg, ports_reg, prio_reg} <=
        {hit_next, drop_next, ovr_next, pv_next, ports_next, prio_next};
    end
  end

  // Pending is registered so software sees it from the cycle after the make write.
  logic pend_reg;
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      pend_reg <= 1'b0;
    else
      pend_reg <= (st_next == addr_table_pkg::ST_MAKE);
  end

  assign reg_rdata_out = rdata_reg;
  assign make_pending_out = pend_reg;
  assign lookup_hit_out = hit_reg;
  assign lookup_ports_out = ports_reg;
  assign lookup_drop_out = drop_reg;
  assign lookup_override_out = ovr_reg;
  assign lookup_prio_valid_out = pv_reg;
  assign lookup_prio_out = prio_reg;

  a_make_pending: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    rise_make && st_reg == addr_table_pkg::ST_IDLE |=> make_pending_out ##1 !make_pending_out)
    else $error("make pending not one cycle");
  a_zero_noop: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    wr_cmd && w_cmd == 3'h0 && st_reg == addr_table_pkg::ST_IDLE
    |=> st_reg == addr_table_pkg::ST_IDLE)
    else $error("zero command started an operation");
  a_get_clears: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (rise_first || rise_next) && st_reg == addr_table_pkg::ST_IDLE && !rise_make
    |=> !rd_valid_reg)
    else $error("valid not cleared on get");
  a_scan_ends: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    st_reg == addr_table_pkg::ST_SCAN |-> ##[1:10] st_reg == addr_table_pkg::ST_IDLE)
    else $error("scan did not finish");
  a_filter_drop: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    lookup_drop_out |-> lookup_hit_out)
    else $error("drop without hit");
  a_prio_gate: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    lookup_prio_valid_out |-> $past(dest_priority_first_in))
    else $error("priority without global enable");
  a_make_stores: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    st_reg == addr_table_pkg::ST_MAKE && (match_hit || free_hit)
    |=> ent0_reg[$past(make_idx)] == $past(wr0_reg))
    else $error("make did not store word0");
  a_level_hold: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    wr_cmd && cmd_reg[addr_table_pkg::CMD_MAKE_BIT] && st_reg == addr_table_pkg::ST_IDLE
    |=> st_reg != addr_table_pkg::ST_MAKE)
    else $error("held bit retriggered");
  c_make: cover property (@(posedge mclk_in) disable iff (!rstn_in) rise_make);
  c_first_found: cover property (@(posedge mclk_in) disable iff (!rstn_in) $rose(rd_valid_reg));
  c_end: cover property (@(posedge mclk_in) disable iff (!rstn_in) $rose(rd_end_reg));
endmodule : address_table_manual_access

// >>> tb_address_table_manual_access.sv
// Self-checking testbench of the address table command and write-data registers.
`timescale 1ns/10ps
module tb_address_table_manual_access;
  logic        mclk_in;
  logic        rstn_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [15:0] reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic [31:0] reg_rdata_out;
  logic [47:0] lookup_da_in;
  logic [47:0] lookup_sa_in;
  logic        lookup_sa_valid_in;
  logic        dest_priority_first_in;
  logic [2:0]  port_disabled_in;
  logic        lookup_hit_out;
  logic [2:0]  lookup_ports_out;
  logic        lookup_drop_out;
  logic        lookup_override_out;
  logic        lookup_prio_valid_out;
  logic [2:0]  lookup_prio_out;
  logic        make_pending_out;
  int          miscompares;
  int          total_checks;
  logic [31:0] r0;
  logic [31:0] r1;
  logic [31:0] q0;
  logic [31:0] q1;
  logic [2:0]  masks [8];

  // Short aging counts keep the aging scenario to a few dozen cycles.
  address_table_manual_access #(.AGE_TICK_CYCLES_P(4), .AGE_TICKS_P(3)) address_table_manual_access_i (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .lookup_da_in(lookup_da_in), .lookup_sa_in(lookup_sa_in),
    .lookup_sa_valid_in(lookup_sa_valid_in), .dest_priority_first_in(dest_priority_first_in),
    .port_disabled_in(port_disabled_in), .lookup_hit_out(lookup_hit_out),
    .lookup_ports_out(lookup_ports_out), .lookup_drop_out(lookup_drop_out),
    .lookup_override_out(lookup_override_out), .lookup_prio_valid_out(lookup_prio_valid_out),
    .lookup_prio_out(lookup_prio_out), .make_pending_out(make_pending_out));

  always #5 mclk_in = ~mclk_in;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d.", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [15:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in   <= 1'b0;
    @(posedge mclk_in);
    #1 d = reg_rdata_out;
  endtask : reg_read

  // Writes the command register and watches four edges for the pending flag.
  task automatic pulse_cmd(input logic [31:0] d, input logic exp_pend);
    logic seen;
    seen = 1'b0;
    reg_write(addr_table_pkg::CMD_OFFSET, d);
    repeat (4)
    begin
      #1 seen = seen | make_pending_out;
      @(posedge mclk_in);
    end
    check("make_pending", {31'h0, seen}, {31'h0, exp_pend});
  endtask : pulse_cmd

  task automatic make_entry(input logic [31:0] w0, input logic [31:0] w1);
    logic [31:0] s;
    reg_write(addr_table_pkg::WR_WORD0_OFFSET, w0);
    reg_write(addr_table_pkg::WR_WORD1_OFFSET, w1);
    pulse_cmd(32'h0000_0004, 1'b1);
    reg_read(addr_table_pkg::CMD_STS_OFFSET, s);
    check("status_after_make", s & 32'h1, 32'h0);
    reg_write(addr_table_pkg::CMD_OFFSET, 32'h0);
  endtask : make_entry

  // Expected value packs hit, port mask, drop, override, priority valid and priority.
  task automatic lookup(input logic [47:0] da, input logic [9:0] exp);
    @(posedge mclk_in);
    lookup_da_in <= da;
    @(posedge mclk_in);
    #1 check("lookup", {22'h0, lookup_hit_out, lookup_ports_out, lookup_drop_out,
                        lookup_override_out, lookup_prio_valid_out, lookup_prio_out},
                 {22'h0, exp});
  endtask : lookup

  task automatic get_cmd(input logic [31:0] cmd, output logic [31:0] d0, output logic [31:0] d1);
    logic [31:0] s;
    reg_write(addr_table_pkg::CMD_OFFSET, cmd);
    s = 32'h2;
    for (int i = 0; i < 20 && s[1] !== 1'b0; i++)
      reg_read(addr_table_pkg::CMD_STS_OFFSET, s);
    check("scan_done", s & 32'h2, 32'h0);
    reg_read(addr_table_pkg::RD_WORD0_OFFSET, d0);
    reg_read(addr_table_pkg::RD_WORD1_OFFSET, d1);
    reg_write(addr_table_pkg::CMD_OFFSET, 32'h0);
  endtask : get_cmd

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    mclk_in = 1'b0;
    rstn_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 16'h0000;
    reg_wdata_in = 32'h0000_0000;
    lookup_da_in = 48'h0;
    lookup_sa_in = 48'h0;
    lookup_sa_valid_in = 1'b0;
    dest_priority_first_in = 1'b1;
    port_disabled_in = 3'h0;
    masks = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
    total_checks = 0;
    miscompares = 0;
    repeat (20) @(posedge mclk_in);
    rstn_in <= 1'b1;
    reg_read(addr_table_pkg::WR_WORD0_OFFSET, r0);
    check("word0_reset", r0, 32'h0000_0000);
    reg_read(addr_table_pkg::WR_WORD1_OFFSET, r1);
    check("word1_reset", r1, 32'h0000_0000);
    reg_read(addr_table_pkg::CMD_OFFSET, r0);
    check("cmd_reset", r0, 32'h0000_0000);
    reg_write(addr_table_pkg::WR_WORD1_OFFSET, 32'hffff_ffff);
    reg_read(addr_table_pkg::WR_WORD1_OFFSET, r1);
    check("word1_reserved", r1, 32'h07ff_ffff);
    // Static entry at MAC 66:55 / 44:33:22:11, every port code except 3 in turn on the same MAC.
    for (int c = 0; c < 8; c++)
    begin
      if (c == 3)
        continue;
      make_entry(32'h4433_2211, {5'h0, 1'b1, 1'b0, 1'b1, 5'h0, c[2:0], 16'h6655});
      lookup({16'h6655, 32'h4433_2211}, {1'b1, masks[c], 6'h0});
    end
    lookup({16'h6655, 32'h4433_2210}, 10'h0);
    pulse_cmd(32'h0000_0004, 1'b1);
    pulse_cmd(32'h0000_0004, 1'b0);
    pulse_cmd(32'h0000_0000, 1'b0);
    make_entry(32'h4433_2211, {5'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h5, 3'h7, 16'h6655});
    lookup({16'h6655, 32'h4433_2211}, {1'b1, 3'h7, 1'b1, 1'b1, 1'b1, 3'h5});
    dest_priority_first_in <= 1'b0;
    lookup({16'h6655, 32'h4433_2211}, {1'b1, 3'h7, 1'b1, 1'b1, 1'b0, 3'h0});
    dest_priority_first_in <= 1'b1;
    port_disabled_in <= 3'h2;
    lookup({16'h6655, 32'h4433_2211}, {1'b1, 3'h5, 1'b1, 1'b1, 1'b1, 3'h5});
    port_disabled_in <= 3'h0;
    make_entry(32'h4433_2211, {5'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h5, 3'h7, 16'h6655});
    lookup({16'h6655, 32'h4433_2211}, {1'b1, 3'h7, 6'h0});
    // Dynamic entry stays while its source address is seen, then ages out.
    // The source is seen from the make onward, so the entry cannot age before the loop.
    lookup_sa_in <= {16'h00b0, 32'h0000_00a0};
    lookup_sa_valid_in <= 1'b1;
    make_entry(32'h0000_00a0, {5'h0, 1'b1, 1'b1, 1'b0, 5'h0, 3'h1, 16'h00b0});
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk_in);
      lookup_sa_valid_in <= 1'b1;
      @(posedge mclk_in);
      lookup_sa_valid_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
    end
    lookup({16'h00b0, 32'h0000_00a0}, {1'b1, 3'h2, 6'h0});
    repeat (40) @(posedge mclk_in);
    lookup({16'h00b0, 32'h0000_00a0}, 10'h0);
    lookup({16'h6655, 32'h4433_2211}, {1'b1, 3'h7, 6'h0});
    // Second static entry, then an entry made and invalidated again.
    make_entry(32'h0000_0101, {5'h0, 1'b1, 1'b0, 1'b1, 5'h0, 3'h2, 16'h0202});
    make_entry(32'h0000_0303, {5'h0, 1'b1, 1'b0, 1'b1, 5'h0, 3'h0, 16'h0404});
    make_entry(32'h0000_0303, {5'h0, 1'b0, 1'b0, 1'b1, 5'h0, 3'h0, 16'h0404});
    lookup({16'h0404, 32'h0000_0303}, 10'h0);
    // Walk: two valid entries in either order, then nothing more.
    get_cmd(32'h0000_0002, r0, r1);
    get_cmd(32'h0000_0001, q0, q1);
    check("walk_first_valid", r1 & 32'h0400_0000, 32'h0400_0000);
    check("walk_next_valid", q1 & 32'h0400_0000, 32'h0400_0000);
    if (r0 === 32'h0000_0101)
    begin
      check("walk_first_word1", r1 & 32'h05ff_ffff, 32'h0502_0202);
      check("walk_next_word0", q0, 32'h4433_2211);
    end
    else
    begin
      check("walk_first_word0", r0, 32'h4433_2211);
      check("walk_next_word0", q0, 32'h0000_0101);
    end
    get_cmd(32'h0000_0001, q0, q1);
    check("walk_end", q1 & 32'h0600_0000, 32'h0200_0000);
    get_cmd(32'h0000_0002, q0, q1);
    check("walk_restart", q0, r0);
    report_and_stop();
  end
endmodule : tb_address_table_manual_access
